// ==== cim_pkg.sv ====
// Package with register map, field positions and reset values for the interrupt mask block.
package cim_pkg;
   localparam logic [7:0] CIM_MASK_ADDR = 8'hA8;
   localparam logic [7:0] CIM_AUX_ADDR = 8'hA6;
   localparam logic [7:0] CIM_MASK_RESET = 8'h00;
   localparam logic [7:0] CIM_AUX_RESET = 8'h00;
   localparam logic [7:0] CIM_RDATA_RESET = 8'h00;
   localparam logic [7:0] CIM_UNMAPPED_RDATA = 8'h00;
   localparam int CIM_GLOBAL_BIT = 7;
   localparam int CIM_SER1_BIT = 6;
   localparam int CIM_TMR2_BIT = 5;
   localparam int CIM_SER0_BIT = 4;
   localparam int CIM_TMR1_BIT = 3;
   localparam int CIM_EXT1_BIT = 2;
   localparam int CIM_TMR0_BIT = 1;
   localparam int CIM_EXT0_BIT = 0;
   localparam int CIM_NSRC = 7;
   localparam int CIM_NAUX = 8;
endpackage

// ==== cim_gate_if.sv ====
// Interface carrying flags and enables to the gate module and pending requests back from it.
`timescale 1ns/10ps
interface cim_gate_if #(parameter int N = 7);
   logic [N-1:0] flag;
   logic [N-1:0] mask;
   logic global_en;
   logic [N-1:0] pend;
   modport gate (input flag, input mask, input global_en, output pend);
   modport ctrl (output flag, output mask, output global_en, input pend);
endinterface

// ==== cim_gate.sv ====
// Registered AND gate of flag, individual enable and global enable.
`timescale 1ns/10ps
module cim_gate #(
   parameter int N = 7
) (
   input wire logic i_clk,
   input wire logic i_rst,
   cim_gate_if.gate g
);
   typedef struct packed {
      logic [N-1:0] pend_r;
   } cim_gate_state_type;
   cim_gate_state_type st_r;
   cim_gate_state_type st_nxt;

   always_comb begin
      st_nxt = st_r;
      st_nxt.pend_r = g.flag & g.mask & {N{g.global_en}};
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign g.pend = st_r.pend_r;
endmodule

// ==== cim_core_irq_mask.sv ====
// Core interrupt enable register with global masking and auxiliary enable register.
`timescale 1ns/10ps
module cim_core_irq_mask
   import cim_pkg::*;
(
   input wire logic I_CLK,
   input wire logic I_RST,
   input wire logic [7:0] I_SFR_ADDR,
   input wire logic I_SFR_WR,
   input wire logic I_SFR_RD,
   input wire logic [7:0] I_SFR_WDATA,
   input wire logic I_SERIAL1_RX_FLAG,
   input wire logic I_SERIAL1_TX_FLAG,
   input wire logic I_TIMER2_OVERFLOW_FLAG,
   input wire logic I_SERIAL0_RX_FLAG,
   input wire logic I_SERIAL0_TX_FLAG,
   input wire logic I_TIMER1_FLAG,
   input wire logic I_EXT1_FLAG,
   input wire logic I_TIMER0_FLAG,
   input wire logic I_EXT0_FLAG,
   input wire logic [CIM_NAUX-1:0] I_AUX_FLAGS,
   output logic [7:0] O_SFR_RDATA,
   output logic [CIM_NSRC-1:0] O_CORE_PEND,
   output logic [CIM_NAUX-1:0] O_AUX_PEND
);
   typedef struct packed {
      logic [7:0] core_interrupt_mask_r;
      logic [7:0] aux_irq_mask_reg_r;
      logic [7:0] rdata_r;
      logic [CIM_NAUX-1:0] aux_pend_r;
   } cim_state_type;
   cim_state_type st_r;
   cim_state_type st_nxt;

   cim_gate_if #(.N(CIM_NSRC)) core_g ();
   logic [CIM_NSRC-1:0] src_flags;

   // Serial ports merge receive and transmit flags into one request each.
   always_comb begin
      src_flags = '0;
      src_flags[CIM_SER1_BIT] = I_SERIAL1_RX_FLAG | I_SERIAL1_TX_FLAG;
      src_flags[CIM_TMR2_BIT] = I_TIMER2_OVERFLOW_FLAG;
      src_flags[CIM_SER0_BIT] = I_SERIAL0_RX_FLAG | I_SERIAL0_TX_FLAG;
      src_flags[CIM_TMR1_BIT] = I_TIMER1_FLAG;
      src_flags[CIM_EXT1_BIT] = I_EXT1_FLAG;
      src_flags[CIM_TMR0_BIT] = I_TIMER0_FLAG;
      src_flags[CIM_EXT0_BIT] = I_EXT0_FLAG;
   end

   assign core_g.flag = src_flags;
   assign core_g.mask = st_r.core_interrupt_mask_r[CIM_NSRC-1:0];
   assign core_g.global_en = st_r.core_interrupt_mask_r[CIM_GLOBAL_BIT];

   // Requests are registered, so a flag reaches the core one edge late; outputs stay on flops.
   cim_gate #(.N(CIM_NSRC)) u_core_gate (
      .i_clk(I_CLK),
      .i_rst(I_RST),
      .g(core_g.gate)
   );

   always_comb begin
      st_nxt = st_r;
      if (I_SFR_WR && I_SFR_ADDR == CIM_MASK_ADDR) begin
         st_nxt.core_interrupt_mask_r = I_SFR_WDATA;
      end
      if (I_SFR_WR && I_SFR_ADDR == CIM_AUX_ADDR) begin
         st_nxt.aux_irq_mask_reg_r = I_SFR_WDATA;
      end
      // The read mux looks at the current registers, so a read beside a write sees the old value.
      if (I_SFR_RD) begin
         case (I_SFR_ADDR)
            CIM_MASK_ADDR: st_nxt.rdata_r = st_r.core_interrupt_mask_r;
            CIM_AUX_ADDR: st_nxt.rdata_r = st_r.aux_irq_mask_reg_r;
            default: st_nxt.rdata_r = CIM_UNMAPPED_RDATA;
         endcase
      end
      // The global enable is deliberately absent here.
      st_nxt.aux_pend_r = I_AUX_FLAGS & st_r.aux_irq_mask_reg_r;
   end

   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         st_r <= '{CIM_MASK_RESET, CIM_AUX_RESET, CIM_RDATA_RESET, '0};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign O_SFR_RDATA = st_r.rdata_r;
   assign O_CORE_PEND = core_g.pend;
   assign O_AUX_PEND = st_r.aux_pend_r;

   global_block_a: assert property (@(posedge I_CLK) disable iff (I_RST)
      !st_r.core_interrupt_mask_r[CIM_GLOBAL_BIT] |=> O_CORE_PEND == '0)
      else $error("Core request seen while global enable clear.");
   global_pass_a: assert property (@(posedge I_CLK) disable iff (I_RST)
      st_r.core_interrupt_mask_r[CIM_GLOBAL_BIT] |=>
      O_CORE_PEND == ($past(src_flags) & $past(st_r.core_interrupt_mask_r[CIM_NSRC-1:0])))
      else $error("Core request does not follow individual enables.");
   pend_cause_a: assert property (@(posedge I_CLK) disable iff (I_RST)
      O_CORE_PEND[CIM_EXT0_BIT] |-> $past(I_EXT0_FLAG) &&
      $past(st_r.core_interrupt_mask_r[CIM_EXT0_BIT]) &&
      $past(st_r.core_interrupt_mask_r[CIM_GLOBAL_BIT]))
      else $error("External 0 request without all three causes.");
   ser1_mask_a: assert property (@(posedge I_CLK) disable iff (I_RST)
      (I_SERIAL1_TX_FLAG && st_r.core_interrupt_mask_r[CIM_SER1_BIT] &&
      st_r.core_interrupt_mask_r[CIM_GLOBAL_BIT]) |=> O_CORE_PEND[CIM_SER1_BIT])
      else $error("Serial 1 transmit request lost.");
   tmr2_mask_a: assert property (@(posedge I_CLK) disable iff (I_RST)
      !st_r.core_interrupt_mask_r[CIM_TMR2_BIT] |=> !O_CORE_PEND[CIM_TMR2_BIT])
      else $error("Timer 2 request passed while disabled.");
   ser0_mask_a: assert property (@(posedge I_CLK) disable iff (I_RST)
      (I_SERIAL0_RX_FLAG && st_r.core_interrupt_mask_r[CIM_SER0_BIT] &&
      st_r.core_interrupt_mask_r[CIM_GLOBAL_BIT]) |=> O_CORE_PEND[CIM_SER0_BIT])
      else $error("Serial 0 receive request lost.");
   global_write_a: assert property (@(posedge I_CLK) disable iff (I_RST)
      (I_SFR_WR && I_SFR_ADDR == CIM_MASK_ADDR && !I_SFR_WDATA[CIM_GLOBAL_BIT])
      |=> ##1 O_CORE_PEND == '0)
      else $error("Clearing global enable did not mask sources.");
   aux_indep_a: assert property (@(posedge I_CLK) disable iff (I_RST)
      1'b1 |=> O_AUX_PEND == ($past(I_AUX_FLAGS) & $past(st_r.aux_irq_mask_reg_r)))
      else $error("Auxiliary request not independent of global enable.");

   // Register file: a write lands one edge later, and nothing but a write or reset moves a mask.
   mask_write_a: assert property (@(posedge I_CLK) disable iff (I_RST)
      (I_SFR_WR && I_SFR_ADDR == CIM_MASK_ADDR) |=>
      st_r.core_interrupt_mask_r == $past(I_SFR_WDATA))
      else $error("Enable register write did not land.");
   aux_write_a: assert property (@(posedge I_CLK) disable iff (I_RST)
      (I_SFR_WR && I_SFR_ADDR == CIM_AUX_ADDR) |=>
      st_r.aux_irq_mask_reg_r == $past(I_SFR_WDATA))
      else $error("Auxiliary enable register write did not land.");
   mask_hold_a: assert property (@(posedge I_CLK) disable iff (I_RST)
      !(I_SFR_WR && I_SFR_ADDR == CIM_MASK_ADDR) |=> $stable(st_r.core_interrupt_mask_r))
      else $error("Enable register changed without a write.");
   aux_hold_a: assert property (@(posedge I_CLK) disable iff (I_RST)
      !(I_SFR_WR && I_SFR_ADDR == CIM_AUX_ADDR) |=> $stable(st_r.aux_irq_mask_reg_r))
      else $error("Auxiliary enable register changed without a write.");
   reset_clear_a: assert property (@(posedge I_CLK) I_RST |=>
      st_r.core_interrupt_mask_r == CIM_MASK_RESET &&
      st_r.aux_irq_mask_reg_r == CIM_AUX_RESET && O_SFR_RDATA == CIM_RDATA_RESET &&
      O_CORE_PEND == '0 && O_AUX_PEND == '0)
      else $error("Reset left a mask, read data or request set.");
   rd_mask_a: assert property (@(posedge I_CLK) disable iff (I_RST)
      (I_SFR_RD && I_SFR_ADDR == CIM_MASK_ADDR) |=>
      O_SFR_RDATA == $past(st_r.core_interrupt_mask_r))
      else $error("Enable register read returned a wrong value.");
   rd_aux_a: assert property (@(posedge I_CLK) disable iff (I_RST)
      (I_SFR_RD && I_SFR_ADDR == CIM_AUX_ADDR) |=>
      O_SFR_RDATA == $past(st_r.aux_irq_mask_reg_r))
      else $error("Auxiliary register read returned a wrong value.");
   rd_unmapped_a: assert property (@(posedge I_CLK) disable iff (I_RST)
      (I_SFR_RD && I_SFR_ADDR != CIM_MASK_ADDR && I_SFR_ADDR != CIM_AUX_ADDR) |=>
      O_SFR_RDATA == CIM_UNMAPPED_RDATA)
      else $error("Unmapped read did not return the idle value.");
   rd_hold_a: assert property (@(posedge I_CLK) disable iff (I_RST)
      !I_SFR_RD |=> $stable(O_SFR_RDATA))
      else $error("Read data moved without a read.");

   // Request path: a core source needs its flag, its own enable and the global enable; an auxiliary one needs no global enable.
   ser1_rx_a: assert property (@(posedge I_CLK) disable iff (I_RST)
      (I_SERIAL1_RX_FLAG && st_r.core_interrupt_mask_r[CIM_SER1_BIT] &&
      st_r.core_interrupt_mask_r[CIM_GLOBAL_BIT]) |=> O_CORE_PEND[CIM_SER1_BIT])
      else $error("Serial 1 receive request lost.");
   ser1_block_a: assert property (@(posedge I_CLK) disable iff (I_RST)
      !st_r.core_interrupt_mask_r[CIM_SER1_BIT] |=> !O_CORE_PEND[CIM_SER1_BIT])
      else $error("Serial 1 request passed while disabled.");
   tmr2_pass_a: assert property (@(posedge I_CLK) disable iff (I_RST)
      (I_TIMER2_OVERFLOW_FLAG && st_r.core_interrupt_mask_r[CIM_TMR2_BIT] &&
      st_r.core_interrupt_mask_r[CIM_GLOBAL_BIT]) |=> O_CORE_PEND[CIM_TMR2_BIT])
      else $error("Timer 2 overflow request lost.");
   ser0_tx_a: assert property (@(posedge I_CLK) disable iff (I_RST)
      (I_SERIAL0_TX_FLAG && st_r.core_interrupt_mask_r[CIM_SER0_BIT] &&
      st_r.core_interrupt_mask_r[CIM_GLOBAL_BIT]) |=> O_CORE_PEND[CIM_SER0_BIT])
      else $error("Serial 0 transmit request lost.");
   ser0_block_a: assert property (@(posedge I_CLK) disable iff (I_RST)
      !st_r.core_interrupt_mask_r[CIM_SER0_BIT] |=> !O_CORE_PEND[CIM_SER0_BIT])
      else $error("Serial 0 request passed while disabled.");
   tmr1_pass_a: assert property (@(posedge I_CLK) disable iff (I_RST)
      (I_TIMER1_FLAG && st_r.core_interrupt_mask_r[CIM_TMR1_BIT] &&
      st_r.core_interrupt_mask_r[CIM_GLOBAL_BIT]) |=> O_CORE_PEND[CIM_TMR1_BIT])
      else $error("Timer 1 request lost.");
   tmr1_block_a: assert property (@(posedge I_CLK) disable iff (I_RST)
      !st_r.core_interrupt_mask_r[CIM_TMR1_BIT] |=> !O_CORE_PEND[CIM_TMR1_BIT])
      else $error("Timer 1 request passed while disabled.");
   ext1_pass_a: assert property (@(posedge I_CLK) disable iff (I_RST)
      (I_EXT1_FLAG && st_r.core_interrupt_mask_r[CIM_EXT1_BIT] &&
      st_r.core_interrupt_mask_r[CIM_GLOBAL_BIT]) |=> O_CORE_PEND[CIM_EXT1_BIT])
      else $error("External 1 request lost.");
   tmr0_pass_a: assert property (@(posedge I_CLK) disable iff (I_RST)
      (I_TIMER0_FLAG && st_r.core_interrupt_mask_r[CIM_TMR0_BIT] &&
      st_r.core_interrupt_mask_r[CIM_GLOBAL_BIT]) |=> O_CORE_PEND[CIM_TMR0_BIT])
      else $error("Timer 0 request lost.");
   ext0_pass_a: assert property (@(posedge I_CLK) disable iff (I_RST)
      (I_EXT0_FLAG && st_r.core_interrupt_mask_r[CIM_EXT0_BIT] &&
      st_r.core_interrupt_mask_r[CIM_GLOBAL_BIT]) |=> O_CORE_PEND[CIM_EXT0_BIT])
      else $error("External 0 request lost.");
   ext0_block_a: assert property (@(posedge I_CLK) disable iff (I_RST)
      !st_r.core_interrupt_mask_r[CIM_EXT0_BIT] |=> !O_CORE_PEND[CIM_EXT0_BIT])
      else $error("External 0 request passed while disabled.");
   no_flag_a: assert property (@(posedge I_CLK) disable iff (I_RST)
      1'b1 |=> (O_CORE_PEND & ~$past(src_flags)) == '0)
      else $error("Core request raised without its flag.");
   own_mask_a: assert property (@(posedge I_CLK) disable iff (I_RST)
      1'b1 |=> (O_CORE_PEND & ~$past(st_r.core_interrupt_mask_r[CIM_NSRC-1:0])) == '0)
      else $error("Core request raised without its own enable.");
   aux_no_flag_a: assert property (@(posedge I_CLK) disable iff (I_RST)
      1'b1 |=> (O_AUX_PEND & ~$past(I_AUX_FLAGS)) == '0)
      else $error("Auxiliary request raised without its flag.");
   aux_own_mask_a: assert property (@(posedge I_CLK) disable iff (I_RST)
      1'b1 |=> (O_AUX_PEND & ~$past(st_r.aux_irq_mask_reg_r)) == '0)
      else $error("Auxiliary request raised without its enable.");
   aux_global_off_a: assert property (@(posedge I_CLK) disable iff (I_RST)
      !st_r.core_interrupt_mask_r[CIM_GLOBAL_BIT] |=>
      O_AUX_PEND == ($past(I_AUX_FLAGS) & $past(st_r.aux_irq_mask_reg_r)))
      else $error("Auxiliary request blocked by the global enable.");
endmodule

// ==== cim_core_irq_mask_tb.sv ====
// Self-checking testbench for the core interrupt enable and mask block.
`timescale 1ns/10ps
module cim_core_irq_mask_tb import cim_pkg::*; ();
   logic i_clk = 1'b0, i_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0, rd_l = 1'b0;
   logic [7:0] i_addr = 8'h00, i_wd = 8'h00, i_aux = 8'h00, o_rd, o_aux, m = 8'h00, a = 8'h00;
   logic [8:0] fl = 9'h000;
   logic [6:0] o_core;
   logic [7:0] rq[$];
   logic [14:0] pq[$];
   int miscompares = 0, tests_run = 0, seed = 32'h6EFB84AE, i;
   cim_core_irq_mask u_cim_core_irq_mask (.I_CLK(i_clk), .I_RST(i_rst), .I_SFR_ADDR(i_addr),
      .I_SFR_WR(i_wr), .I_SFR_RD(i_rd), .I_SFR_WDATA(i_wd), .I_SERIAL1_RX_FLAG(fl[8]),
      .I_SERIAL1_TX_FLAG(fl[7]), .I_TIMER2_OVERFLOW_FLAG(fl[6]), .I_SERIAL0_RX_FLAG(fl[5]),
      .I_SERIAL0_TX_FLAG(fl[4]), .I_TIMER1_FLAG(fl[3]), .I_EXT1_FLAG(fl[2]),
      .I_TIMER0_FLAG(fl[1]), .I_EXT0_FLAG(fl[0]), .I_AUX_FLAGS(i_aux), .O_SFR_RDATA(o_rd),
      .O_CORE_PEND(o_core), .O_AUX_PEND(o_aux));
   initial begin
      forever #5 i_clk = ~i_clk;
   end
   always @(posedge i_clk) begin
      rd_l <= i_rd;
   end
   task automatic results();
      if (miscompares == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic cmp_rd(input logic [7:0] e);
      tests_run++;
      if (o_rd !== e) begin
         miscompares++;
         $display("[ERR] sfr_rdata exp %h got %h", e, o_rd);
      end
   endtask
   task automatic cmp_pend(input logic [14:0] e);
      tests_run++;
      if ({o_core, o_aux} !== e) begin
         miscompares++;
         $display("[ERR] core_aux_pend exp %h got %h", e, {o_core, o_aux});
      end
   endtask
   task automatic wr(input logic [7:0] ad, input logic [7:0] dt);
      @(posedge i_clk);
      #1;
      i_addr = ad;
      i_wd = dt;
      i_wr = 1'b1;
      if (ad == CIM_MASK_ADDR) m = dt;
      if (ad == CIM_AUX_ADDR) a = dt;
      @(posedge i_clk);
      #1;
      i_wr = 1'b0;
   endtask
   task automatic rd(input logic [7:0] ad);
      @(posedge i_clk);
      #1;
      i_addr = ad;
      i_rd = 1'b1;
      rq.push_back(ad == CIM_MASK_ADDR ? m : (ad == CIM_AUX_ADDR ? a : CIM_UNMAPPED_RDATA));
      @(posedge i_clk);
      #1;
      i_rd = 1'b0;
   endtask
   // Pending outputs lag a mask write by two edges, so the note waits that long.
   task automatic src(input logic [8:0] f, input logic [7:0] ax);
      logic [6:0] s;
      @(posedge i_clk);
      #1;
      fl = f;
      i_aux = ax;
      s = {f[8] | f[7], f[6], f[5] | f[4], f[3:0]};
      repeat (2) @(posedge i_clk);
      #1;
      pq.push_back({s & m[6:0] & {7{m[CIM_GLOBAL_BIT]}}, ax & a});
   endtask
   initial begin
      forever begin
         @(posedge i_clk);
         #2;
         if (rd_l) cmp_rd(rq.pop_front());
         if (pq.size() > 0) cmp_pend(pq.pop_front());
      end
   end
   initial begin
      repeat (20000) @(posedge i_clk);
      miscompares++;
      results();
   end
   initial begin
      repeat (2) @(posedge i_clk);
      #1;
      i_rst = 1'b0;
      rd(CIM_MASK_ADDR);
      rd(CIM_AUX_ADDR);
      rd(8'hA7);
      wr(CIM_MASK_ADDR, 8'h7F);
      wr(CIM_AUX_ADDR, 8'hFF);
      src(9'h1FF, 8'hFF);
      wr(8'hA7, 8'hFF);
      rd(CIM_MASK_ADDR);
      wr(CIM_MASK_ADDR, 8'hFF);
      for (i = 0; i < 9; i++) begin
         src(9'h001 << i, 8'h01 << (i % 8));
      end
      for (i = 0; i < 7; i++) begin
         wr(CIM_MASK_ADDR, 8'h80 | (8'h01 << i));
         src(9'h1FF, 8'h00);
      end
      // A reset in mid-run must clear both masks with the flags still raised.
      i_rst = 1'b1;
      m = CIM_MASK_RESET;
      a = CIM_AUX_RESET;
      repeat (2) @(posedge i_clk);
      #1;
      i_rst = 1'b0;
      rd(CIM_MASK_ADDR);
      src(9'h1FF, 8'hFF);
      for (i = 0; i < 24; i++) begin
         wr(CIM_MASK_ADDR, 8'($random(seed)));
         wr(CIM_AUX_ADDR, 8'($random(seed)));
         src(9'($random(seed)), 8'($random(seed)));
         rd(CIM_AUX_ADDR);
         rd(CIM_MASK_ADDR);
      end
      repeat (3) @(posedge i_clk);
      results();
   end
endmodule
